// ---- bench/adc_core_model.sv ----
`timescale 1ns/1ps
// ========================================================================
// converter core: result encodes the selected input, for easy checking
module adc_core_model (
    // clock
    input  wire logic       CLK,
    // from sequencer
    input  wire logic       ANALOG_POWER,
    input  wire logic [2:0] MUX_CHANNEL,
    input  wire logic       MUX_GROUP,
    // to sequencer
    output logic      [9:0] CORE_RESULT
);
    logic [9:0] drift = 10'h155;
    // unpowered core toggles, so a stale value never passes for a result
    always @(posedge CLK) begin
        drift <= ~drift;
    end
    assign CORE_RESULT = ANALOG_POWER ? {MUX_GROUP, MUX_CHANNEL, 6'h2D} : drift;
endmodule // adc_core_model

// ---- bench/tb_adc_sequencer_control.sv ----
`timescale 1ns/1ps
module tb_adc_sequencer_control;
    // ====================================================================
    // signals
    logic        clk = 0, rst_n = 0, special = 0, wait_m = 0, dbg = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq, apow, ck;
    logic        smp, grp;
    logic [1:0]  bresp, rresp, rr;
    logic [2:0]  mch;
    logic [9:0]  core;
    int          err_count = 0, comparisons = 0, cycles = 0;
    int          ticks = 0, samples = 0, s0;
    // ====================================================================
    // design and converter model
    adc_seq_ctrl dut_u (.CLK(clk), .RST_N(rst_n), .SPECIAL_MODE(special),
        .WAIT_MODE(wait_m), .DEBUG_ACTIVE(dbg), .S_AWADDR(awaddr),
        .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata),
        .S_WSTRB(4'hF), .S_WVALID(wvalid), .S_WREADY(wready),
        .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
        .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
        .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
        .S_RREADY(rready), .ANALOG_POWER(apow), .CONV_CLK_EN(ck),
        .SAMPLE(smp), .MUX_CHANNEL(mch), .MUX_GROUP(grp),
        .CORE_RESULT(core), .SEQ_IRQ(irq));
    adc_core_model core_u (.CLK(clk), .ANALOG_POWER(apow),
        .MUX_CHANNEL(mch), .MUX_GROUP(grp), .CORE_RESULT(core));
    // ====================================================================
    // bus tasks: one edge of spacing at entry keeps drivers single-assigned
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
        {awvalid, wvalid} <= 2'b00;
        do @(posedge clk); while (bvalid !== 1'b1);
        rr = bresp;
        bready <= 0;
    endtask
    task automatic rg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        rready <= 0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // poll status until the sequence done flag shows, bounded
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            rg(adc_seq_pkg::OFF_STATUS);
            n++;
        end while (rd[7] !== 1'b1 && n < 400);
    endtask
    // converter clock pulses over 80 system clocks, after a settling gap
    task automatic tick_window(input int exp);
        int t0;
        repeat (10) @(posedge clk);
        t0 = ticks;
        repeat (80) @(posedge clk);
        chk(ticks - t0, exp);
    endtask
    // expected result: 8-bit mode drops the two low bits
    function automatic logic [31:0] res(input logic [3:0] c, input logic t);
        return {22'h0, {c, 6'h2D} & (t ? 10'h3FF : 10'h3FC)};
    endfunction
    task automatic results();
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ====================================================================
    // clock and hang guard
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            results();
        end
    end
    // converter clock pulses and sample-phase cycles seen at the core
    always @(posedge clk) begin
        if (ck === 1'b1) ticks <= ticks + 1;
        if (smp === 1'b1) samples <= samples + 1;
    end
    // ====================================================================
    // test sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rg(adc_seq_pkg::OFF_TIMING);
        chk(rd, 32'h0000_0001);
        rg(adc_seq_pkg::OFF_RESERVED);
        chk({30'h0, rr}, {30'h0, adc_seq_pkg::AXI_SLVERR});
        special <= 1;
        rg(adc_seq_pkg::OFF_RESERVED);
        chk({30'h0, rr}, {30'h0, adc_seq_pkg::AXI_OKAY});
        special <= 0;
        rg(8'h1C);
        chk({30'h0, rr}, {30'h0, adc_seq_pkg::AXI_SLVERR});
        wr(8'h40, 32'h0000_0000);
        chk({30'h0, rr}, {30'h0, adc_seq_pkg::AXI_SLVERR});
        wr(adc_seq_pkg::OFF_POWER_IRQ, 32'h0000_0083);
        chk({30'h0, rr}, {30'h0, adc_seq_pkg::AXI_OKAY});
        rg(adc_seq_pkg::OFF_POWER_IRQ);
        chk(rd, 32'h0000_0082);
        chk({31'h0, apow}, 32'h0000_0001);
        tick_window(20);
        // single mode, four conversions of channel five, 8-bit
        wr(adc_seq_pkg::OFF_TIMING, 32'h0000_0000);
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0005);
        wait_done();
        chk(rd & 32'h0000_FF80, 32'h0000_0F80);
        chk({31'h0, irq}, 32'h0000_0001);
        rg(adc_seq_pkg::OFF_RESULT_BASE);
        chk(rd, res(4'h5, 1'b0));
        repeat (400) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_FF80, 32'h0000_0E80);
        // eight conversions stepping channels, 10-bit
        wr(adc_seq_pkg::OFF_TIMING, 32'h0000_0080);
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0050);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_FF87, 32'h0000_0000);
        wait_done();
        chk(rd & 32'h0000_FF80, 32'h0000_FF80);
        for (int i = 0; i < 8; i++) begin
            rg(adc_seq_pkg::OFF_RESULT_BASE + 8'(4 * i));
            chk(rd, res(4'(i), 1'b1));
        end
        // scan mode restarts, then a control zero write aborts it
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0070);
        wait_done();
        rg(adc_seq_pkg::OFF_RESULT_BASE);
        repeat (700) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0180, 32'h0000_0180);
        wr(adc_seq_pkg::OFF_CTRL_ZERO, 32'h0000_0000);
        repeat (200) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0007, 32'h0000_0000);
        // converter clock rate, wait stop and freeze gating
        wr(adc_seq_pkg::OFF_TIMING, 32'h0000_0003);
        tick_window(10);
        wr(adc_seq_pkg::OFF_POWER_IRQ, 32'h0000_00A0);
        wait_m <= 1;
        tick_window(0);
        wr(adc_seq_pkg::OFF_POWER_IRQ, 32'h0000_0080);
        tick_window(10);
        wait_m <= 0;
        wr(adc_seq_pkg::OFF_FREEZE, 32'h0000_00C0);
        dbg <= 1;
        tick_window(0);
        dbg <= 0;
        // finishing freeze holds the sequence at a conversion boundary
        wr(adc_seq_pkg::OFF_FREEZE, 32'h0000_0080);
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0005);
        dbg <= 1;
        repeat (400) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0086, 32'h0000_0000);
        dbg <= 0;
        wait_done();
        chk(rd & 32'h0000_0080, 32'h0000_0080);
        // timing and freeze writes abort a running sequence
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0005);
        repeat (200) @(posedge clk);
        wr(adc_seq_pkg::OFF_TIMING, 32'h0000_0060);
        repeat (300) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0087, 32'h0000_0000);
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0005);
        repeat (200) @(posedge clk);
        wr(adc_seq_pkg::OFF_FREEZE, 32'h0000_0000);
        repeat (300) @(posedge clk);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0087, 32'h0000_0000);
        // long sample phase, upper channel group, interrupt masked
        s0 = samples;
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_000D);
        wait_done();
        chk({31'h0, irq}, 32'h0000_0000);
        // first sample phase starts mid tick, so up to three cycles short
        chk((samples - s0 + 3) / 4, 32'h0000_0040);
        rg(adc_seq_pkg::OFF_RESULT_BASE);
        chk(rd, res(4'hD, 1'b0));
        // fast clear: result read alone clears its flag and done
        wr(adc_seq_pkg::OFF_POWER_IRQ, 32'h0000_00C2);
        wr(adc_seq_pkg::OFF_MODE, 32'h0000_0005);
        wait_done();
        rg(adc_seq_pkg::OFF_RESULT_BASE);
        rg(adc_seq_pkg::OFF_STATUS);
        chk(rd & 32'h0000_0180, 32'h0000_0000);
        wr(adc_seq_pkg::OFF_POWER_IRQ, 32'h0000_0000);
        chk({31'h0, apow}, 32'h0000_0000);
        results();
    end
endmodule // tb_adc_sequencer_control

// ---- hw/adc_seq_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - eight-channel bit sets four or eight conversions
// - single mode sets done flag then halts
// - scan mode sets done, restarts forever
// - result load sets flag, read clears
// - control zero write aborts the sequence
// - reserved register reads special only, ignores writes
// - control two write aborts; irq flag unwritable
// - power down gates clock and aborts
// - fast clear selects read-clear discipline
// - wait-stop halts converter in wait mode
// - irq flag set; request only if enabled
// - control three write aborts sequence
// - freeze field selects debug response
// - timing write aborts; idle till mode write
// - resolution bit selects eight or ten bits
// - sample phase 2..16 plus 16/18 clocks
// - prescaler divides by value plus one, halved; zero acts as one
// - reset prescale gives total divide by four
// - mode write starts sequence, clears flags; a sequence end in the same cycle still sets done and irq
// - multichannel steps channels, else one channel
// - everything timed from the one system clock
// - done flag clear depends on fast clear
// - three-bit counter shows next result slot
module adc_seq_ctrl #(
    parameter int RES_W = 10
) (
    // system
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SPECIAL_MODE,
    input  wire logic        WAIT_MODE,
    input  wire logic        DEBUG_ACTIVE,
    // axi4-lite slave
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    output logic [1:0]       S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    output logic [31:0]      S_RDATA,
    output logic [1:0]       S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY,
    // converter core
    output logic             ANALOG_POWER,
    output logic             CONV_CLK_EN,
    output logic             SAMPLE,
    output logic [2:0]       MUX_CHANNEL,
    output logic             MUX_GROUP,
    input  wire logic [RES_W-1:0] CORE_RESULT,
    // interrupt request
    output logic             SEQ_IRQ
);
    // refuse widths the result packing cannot serve
    if (RES_W != 10) begin : g_width_check
        $error("result width must be 10");
    end
    // ========================================================================
    // registers
    adc_seq_pkg::cfg_s cfg;
    logic [7:0]  ctrl_zero;
    logic        seq_done;
    logic        irq_flag;
    logic [7:0]  ccf;
    logic [7:0]  status_seen;
    logic [2:0]  count;
    logic [RES_W-1:0] result [8];
    typedef enum {ST_IDLE, ST_CONV, ST_HALT} state_e;
    state_e      state;
    logic [5:0]  phase;
    logic [4:0]  pre_cnt;
    logic        half;
    logic        atd_tick;
    // ========================================================================
    // bus handshakes: write taken when address and data both present
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic        wr_ok;
    assign wa        = S_AWADDR;
    assign ra        = S_ARADDR;
    assign wr_go     = S_AWVALID && S_WVALID && !S_BVALID;
    assign rd_go     = S_ARVALID && !S_RVALID;
    assign S_AWREADY = wr_go;
    assign S_WREADY  = wr_go;
    assign S_ARREADY = rd_go;
    logic w_zero, w_pwr, w_frz, w_tim, w_mode;
    assign wr_ok  = wr_go && S_WSTRB[0];
    assign w_zero = wr_ok && wa == adc_seq_pkg::OFF_CTRL_ZERO;
    assign w_pwr  = wr_ok && wa == adc_seq_pkg::OFF_POWER_IRQ;
    assign w_frz  = wr_ok && wa == adc_seq_pkg::OFF_FREEZE;
    assign w_tim  = wr_ok && wa == adc_seq_pkg::OFF_TIMING;
    assign w_mode = wr_ok && wa == adc_seq_pkg::OFF_MODE;
    // result slot hit by read or write (fast clear counts any access)
    logic       r_res, w_res, r_stat;
    logic [2:0] r_idx, w_idx;
    assign r_res  = rd_go && ra >= adc_seq_pkg::OFF_RESULT_BASE
                    && ra <= adc_seq_pkg::OFF_RESULT_LAST;
    assign w_res  = wr_go && wa >= adc_seq_pkg::OFF_RESULT_BASE
                    && wa <= adc_seq_pkg::OFF_RESULT_LAST;
    assign r_idx  = ra[4:2];
    assign w_idx  = wa[4:2];
    assign r_stat = rd_go && ra == adc_seq_pkg::OFF_STATUS;
    // any abort: control writes or power down
    logic abort;
    assign abort = w_zero || w_pwr || w_frz || w_tim || w_mode
                   || !cfg.power_up;
    // ========================================================================
    // configuration registers; irq flag bit is never taken from the bus
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg       <= '0;
            ctrl_zero <= adc_seq_pkg::RST_ZERO;
            cfg.prs   <= adc_seq_pkg::RST_TIMING[4:0];
        end else begin
            if (w_zero) ctrl_zero <= S_WDATA[7:0];
            if (w_pwr) begin
                cfg.power_up  <= S_WDATA[adc_seq_pkg::POS_POWER_UP];
                cfg.fast_clr  <= S_WDATA[adc_seq_pkg::POS_FAST_CLR];
                cfg.wait_stop <= S_WDATA[adc_seq_pkg::POS_WAIT_STOP];
                cfg.irq_en    <= S_WDATA[adc_seq_pkg::POS_IRQ_EN];
            end
            if (w_frz) cfg.freeze <= S_WDATA[7:6];
            if (w_tim) begin
                cfg.ten_bit <= S_WDATA[adc_seq_pkg::POS_TEN_BIT];
                cfg.smp     <= S_WDATA[adc_seq_pkg::POS_SMP_LO +: 2];
                cfg.prs     <= S_WDATA[adc_seq_pkg::POS_PRS_LO +: 5];
            end
            if (w_mode) begin
                cfg.eight <= S_WDATA[adc_seq_pkg::POS_EIGHT];
                cfg.scan  <= S_WDATA[adc_seq_pkg::POS_SCAN];
                cfg.multichannel_enable  <= S_WDATA[adc_seq_pkg::POS_MULTICHANNEL_ENABLE];
                cfg.chan  <= S_WDATA[3:0];
            end
        end
    end
    // ========================================================================
    // stall conditions: wait mode and debug freeze
    logic stall;
    logic frz_now;
    assign frz_now = DEBUG_ACTIVE && cfg.freeze == adc_seq_pkg::FREEZE_NOW;
    assign stall   = (WAIT_MODE && cfg.wait_stop) || frz_now;
    // ========================================================================
    // prescaler: count prs+1 system clocks per half period, so the
    // converter clock is symmetric; zero code behaves as one
    logic [4:0] prs_eff;
    assign prs_eff = (cfg.prs == 5'h00) ? 5'h01 : cfg.prs;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_cnt <= '0;
            half    <= 1'b0;
        end else if (!cfg.power_up || stall) begin
            pre_cnt <= '0;
            half    <= 1'b0;
        end else if (pre_cnt == prs_eff) begin
            pre_cnt <= '0;
            half    <= !half;
        end else begin
            pre_cnt <= pre_cnt + 5'h01;
        end
    end
    // one converter clock per full period of the halved signal
    assign atd_tick = cfg.power_up && !stall && half && pre_cnt == prs_eff;
    // ========================================================================
    // conversion length: sample phase plus resolution-dependent tail
    logic [5:0] conv_len;
    always_comb begin
        conv_len = (adc_seq_pkg::SMP_BASE << cfg.smp)
                   + (cfg.ten_bit ? adc_seq_pkg::EXTRA_10BIT
                                  : adc_seq_pkg::EXTRA_8BIT);
    end
    logic [2:0] last_slot;
    assign last_slot = cfg.eight ? 3'h7 : 3'h3;
    logic conv_end;
    assign conv_end = state == ST_CONV && atd_tick && phase == conv_len - 6'h01;
    // finishing freeze holds at a conversion boundary
    logic frz_end;
    assign frz_end = DEBUG_ACTIVE && cfg.freeze == adc_seq_pkg::FREEZE_FINISH;
    // ========================================================================
    // sequencer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            phase <= '0;
            count <= '0;
        end else if (w_mode && cfg.power_up) begin
            state <= ST_CONV;
            phase <= '0;
            count <= '0;
        end else if (abort) begin
            state <= ST_IDLE;
            phase <= '0;
            count <= '0;
        end else if (state == ST_CONV && frz_end && phase == 6'h00) begin
            phase <= '0;
        end else if (conv_end) begin
            phase <= '0;
            count <= (count == last_slot) ? 3'h0 : count + 3'h1;
            if (count == last_slot && !cfg.scan)
                state <= ST_HALT;
        end else if (state == ST_CONV && atd_tick) begin
            phase <= phase + 6'h01;
        end
    end
    // ========================================================================
    // result capture and per-slot complete flags; set beats clear
    logic [7:0] clr_ccf;
    always_comb begin
        clr_ccf = '0;
        if (cfg.fast_clr) begin
            if (r_res) clr_ccf[r_idx] = 1'b1;
            if (w_res) clr_ccf[w_idx] = 1'b1;
        end else if (r_res && status_seen[r_idx]) begin
            clr_ccf[r_idx] = 1'b1;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ccf         <= '0;
            status_seen <= '0;
        end else if (w_mode) begin
            ccf         <= '0;
            status_seen <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (conv_end && count == 3'(i)) begin
                    ccf[i]         <= 1'b1;
                    status_seen[i] <= 1'b0;
                end else begin
                    if (clr_ccf[i]) ccf[i] <= 1'b0;
                    if (clr_ccf[i]) status_seen[i] <= 1'b0;
                    else if (r_stat && ccf[i]) status_seen[i] <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < 8; i++) result[i] <= '0;
        end else if (conv_end) begin
            result[count] <= cfg.ten_bit ? CORE_RESULT
                             : {CORE_RESULT[RES_W-1:2], 2'b00};
        end
    end
    // ========================================================================
    // sequence complete and interrupt flag
    logic seq_last;
    assign seq_last = conv_end && count == last_slot;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            seq_done <= 1'b0;
            irq_flag <= 1'b0;
        end else if (seq_last) begin
            seq_done <= 1'b1;
            irq_flag <= 1'b1;
        end else if (w_mode && !cfg.fast_clr) begin
            seq_done <= 1'b0;
            irq_flag <= 1'b0;
        end else if (w_mode
                     || (cfg.fast_clr && r_res && r_idx == 3'h0)) begin
            seq_done <= 1'b0;
            irq_flag <= 1'b0;
        end
    end
    assign SEQ_IRQ = irq_flag && cfg.irq_en;
    // ========================================================================
    // converter core drive
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MUX_CHANNEL <= '0;
            MUX_GROUP   <= 1'b0;
            SAMPLE      <= 1'b0;
        end else begin
            MUX_CHANNEL <= cfg.multichannel_enable ? (cfg.eight ? count
                                      : {cfg.chan[2], count[1:0]})
                                    : cfg.chan[2:0];
            MUX_GROUP   <= cfg.chan[3];
            SAMPLE      <= state == ST_CONV
                           && phase < (adc_seq_pkg::SMP_BASE << cfg.smp);
        end
    end
    assign ANALOG_POWER = cfg.power_up;
    assign CONV_CLK_EN  = atd_tick;
    // ========================================================================
    // write response
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            S_BVALID <= 1'b0;
            S_BRESP  <= adc_seq_pkg::AXI_OKAY;
        end else if (wr_go) begin
            S_BVALID <= 1'b1;
            S_BRESP  <= (wa[7:6] == 2'b00) ? adc_seq_pkg::AXI_OKAY
                                           : adc_seq_pkg::AXI_SLVERR;
        end else if (S_BREADY) begin
            S_BVALID <= 1'b0;
        end
    end
    // ========================================================================
    // read data; reserved register only visible in special mode
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            S_RVALID <= 1'b0;
            S_RDATA  <= '0;
            S_RRESP  <= adc_seq_pkg::AXI_OKAY;
        end else if (rd_go) begin
            S_RVALID <= 1'b1;
            S_RRESP  <= adc_seq_pkg::AXI_OKAY;
            S_RDATA  <= '0;
            if (ra == adc_seq_pkg::OFF_CTRL_ZERO)
                S_RDATA[7:0] <= ctrl_zero;
            else if (ra == adc_seq_pkg::OFF_RESERVED)
                S_RDATA[7:0] <= 8'h00;
            else if (ra == adc_seq_pkg::OFF_POWER_IRQ)
                S_RDATA[7:0] <= {cfg.power_up, cfg.fast_clr, cfg.wait_stop,
                                 3'b000, cfg.irq_en, irq_flag};
            else if (ra == adc_seq_pkg::OFF_FREEZE)
                S_RDATA[7:0] <= {cfg.freeze, 6'h00};
            else if (ra == adc_seq_pkg::OFF_TIMING)
                S_RDATA[7:0] <= {cfg.ten_bit, cfg.smp, cfg.prs};
            else if (ra == adc_seq_pkg::OFF_MODE)
                S_RDATA[7:0] <= {1'b0, cfg.eight, cfg.scan, cfg.multichannel_enable,
                                 cfg.chan};
            else if (ra == adc_seq_pkg::OFF_STATUS)
                S_RDATA[15:0] <= {ccf, seq_done, 4'h0, count};
            else if (r_res)
                S_RDATA[RES_W-1:0] <= result[r_idx];
            else if (ra[7:6] != 2'b00 || ra == 8'h1C)
                S_RRESP <= adc_seq_pkg::AXI_SLVERR;
            if (ra == adc_seq_pkg::OFF_RESERVED && !SPECIAL_MODE)
                S_RRESP <= adc_seq_pkg::AXI_SLVERR;
        end else if (S_RREADY) begin
            S_RVALID <= 1'b0;
        end
    end
    // ========================================================================
    // checks
    sequence_done_a: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_last |=> seq_done && irq_flag)
        else $error("sequence end did not set flags");
    irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
        SEQ_IRQ |-> cfg.irq_en && irq_flag)
        else $error("interrupt raised while disabled");
    single_halt_a: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_last && !cfg.scan && !w_mode && !abort |=> state == ST_HALT)
        else $error("single sequence did not halt");
    scan_restart_a: assert property (@(posedge CLK) disable iff (!RST_N)
        seq_last && cfg.scan && !abort |=> state == ST_CONV && count == 0)
        else $error("scan did not restart");
    abort_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
        abort && !(w_mode && cfg.power_up) |=> state == ST_IDLE && count == 0)
        else $error("abort left sequencer running");
    ccf_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
        conv_end && !w_mode |=> ccf[$past(count)])
        else $error("complete flag not set on load");
    power_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !cfg.power_up |-> !CONV_CLK_EN ##1 state == ST_IDLE)
        else $error("converter ran while powered down");
    irq_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        w_pwr && !seq_last && !r_res |=> $stable(irq_flag))
        else $error("bus write changed the interrupt flag");
    mode_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        w_mode && !seq_last |=> ccf == 8'h00 && !seq_done)
        else $error("start did not clear flags");
    tick_space_a: assert property (@(posedge CLK) disable iff (!RST_N)
        atd_tick && !stall && $stable(cfg.prs) |=> !atd_tick [*3])
        else $error("converter clock too fast");
endmodule // adc_seq_ctrl

// ---- hw/adc_seq_pkg.sv ----
package adc_seq_pkg;
    // ========================================================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL_ZERO   = 8'h00;
    localparam logic [7:0] OFF_RESERVED    = 8'h04;
    localparam logic [7:0] OFF_POWER_IRQ   = 8'h08;
    localparam logic [7:0] OFF_FREEZE      = 8'h0C;
    localparam logic [7:0] OFF_TIMING      = 8'h10;
    localparam logic [7:0] OFF_MODE        = 8'h14;
    localparam logic [7:0] OFF_STATUS      = 8'h18;
    localparam logic [7:0] OFF_RESULT_BASE = 8'h20;
    localparam logic [7:0] OFF_RESULT_LAST = 8'h3C;
    // ========================================================================
    // power/irq control field positions
    localparam int POS_POWER_UP  = 7;
    localparam int POS_FAST_CLR  = 6;
    localparam int POS_WAIT_STOP = 5;
    localparam int POS_IRQ_EN    = 1;
    localparam int POS_IRQ_FLAG  = 0;
    // timing control fields
    localparam int POS_TEN_BIT   = 7;
    localparam int POS_SMP_LO    = 5;
    localparam int POS_PRS_LO    = 0;
    // mode control fields
    localparam int POS_EIGHT     = 6;
    localparam int POS_SCAN      = 5;
    localparam int POS_MULTICHANNEL_ENABLE      = 4;
    // status fields
    localparam int POS_SEQ_DONE  = 7;
    localparam int POS_COUNT_LO  = 0;
    localparam int POS_CCF_LO    = 8;
    // ========================================================================
    // reset values
    localparam logic [7:0] RST_TIMING    = 8'h01;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    // ========================================================================
    // conversion timing in converter clocks, then freeze and bus response codes
    localparam logic [5:0] SMP_BASE      = 6'h02;
    localparam logic [5:0] EXTRA_8BIT    = 6'h10;
    localparam logic [5:0] EXTRA_10BIT   = 6'h12;
    localparam logic [1:0] FREEZE_RUN    = 2'b00;
    localparam logic [1:0] FREEZE_FINISH = 2'b10;
    localparam logic [1:0] FREEZE_NOW    = 2'b11;
    localparam logic [1:0] AXI_OKAY      = 2'b00;
    localparam logic [1:0] AXI_SLVERR    = 2'b10;

    typedef struct packed {
        logic       power_up;
        logic       fast_clr;
        logic       wait_stop;
        logic       irq_en;
        logic [1:0] freeze;
        logic       ten_bit;
        logic [1:0] smp;
        logic [4:0] prs;
        logic       eight;
        logic       scan;
        logic       multichannel_enable;
        logic [3:0] chan;
    } cfg_s;
endpackage
